// File: hw/usb_ep_pkg.sv
// Constants shared by the bulk endpoint buffer control logic.
// Assumes an 8-bit register port and four endpoint slots.
`default_nettype none
package usb_ep_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_EP = 4;
  localparam int EP_IDX_W = 2;
  localparam int CNT_W = 11;
  localparam int BCH_W = 3;
  localparam int RAM_AW_DEF = 6;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] CFG_BASE = 8'h00;
  localparam logic [7:0] BCH_BASE = 8'h04;
  localparam logic [7:0] BCL_BASE = 8'h08;
  localparam logic [7:0] EP_STAT_OFF = 8'h0C;
  localparam logic [7:0] IBN_EN_OFF = 8'h0D;
  localparam logic [7:0] IBN_REQ_OFF = 8'h0E;
  localparam logic [7:0] GNAK_EN_OFF = 8'h0F;
  localparam logic [7:0] GNAK_REQ_OFF = 8'h10;
  localparam logic [7:0] APTR_SETUP_OFF = 8'h11;
  localparam logic [7:0] PTR_A_OFF = 8'h12;
  localparam logic [7:0] PTR_B_OFF = 8'h13;
  localparam logic [7:0] DATA_A_OFF = 8'h14;
  localparam logic [7:0] DATA_B_OFF = 8'h15;

  // ==========================================================
  // Field positions and encodings
  localparam int CFG_VALID_BIT = 7;
  localparam int CFG_DIR_BIT = 6;
  localparam int CFG_TYPE_MSB = 5;
  localparam int CFG_TYPE_LSB = 4;
  localparam int CFG_BUF_MSB = 1;
  localparam int CFG_BUF_LSB = 0;
  localparam logic [1:0] CFG_TYPE_BULK = 2'h2;
  localparam logic [1:0] CFG_BUF_DOUBLE = 2'h2;
  localparam logic [7:0] CFG_BULK_OUT_DBL = 8'hA2;
  localparam logic [7:0] CFG_BULK_IN_DBL = 8'hE2;
  localparam int SKIP_BIT = 7;
  localparam int AUTOINC_BIT = 0;
  localparam int GLOBAL_IBN_BIT = 0;
  localparam int STAT_FULL_LSB = 4;

  // ==========================================================
  // Reset value and buffer capacities
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] CAP_SINGLE = 2'h1;
  localparam logic [1:0] CAP_DOUBLE = 2'h2;

endpackage : usb_ep_pkg
`default_nettype wire

// File: hw/ep_buffer_track.sv
// Buffer bookkeeping for one bulk endpoint: arming, filled packets and lengths.
// Assumes the caller only presents host tokens when host_ok_o is high.
`timescale 1ns/1ps
`default_nettype none
module ep_buffer_track
  import usb_ep_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] cfg_i,
  input wire logic cfg_wr_i,
  input wire logic skip_i,
  input wire logic commit_i,
  input wire logic [CNT_W-1:0] commit_len_i,
  input wire logic host_out_i,
  input wire logic [CNT_W-1:0] host_len_i,
  input wire logic host_in_i,
  output logic host_ok_o,
  output logic empty_o,
  output logic full_o,
  output logic [CNT_W-1:0] head_len_o
);

  typedef struct packed {
    logic [1:0] qn;
    logic [1:0] armed;
    logic rd;
    logic [1:0][CNT_W-1:0] len;
  } ep_state_t;

  ep_state_t s_ff;
  ep_state_t nxt_s;
  logic is_in;
  logic active;
  logic [1:0] cap;
  logic push;
  logic pop;
  logic release_buf;

  assign is_in = cfg_i[CFG_DIR_BIT];
  assign active = cfg_i[CFG_VALID_BIT] && (cfg_i[CFG_TYPE_MSB:CFG_TYPE_LSB] == CFG_TYPE_BULK);
  assign cap = (cfg_i[CFG_BUF_MSB:CFG_BUF_LSB] == CFG_BUF_DOUBLE) ? CAP_DOUBLE : CAP_SINGLE;
  assign host_ok_o = active && (is_in ? (s_ff.qn != 2'h0) : (s_ff.armed != 2'h0));
  assign empty_o = (s_ff.qn == 2'h0);
  assign full_o = (s_ff.qn == cap);
  assign head_len_o = s_ff.len[s_ff.rd];

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_s = s_ff;
    // A skip on a filled buffer hands it back empty; on an idle one it arms a spare.
    release_buf = !is_in && skip_i && ((s_ff.qn != 2'h0) || ((s_ff.armed + s_ff.qn) < cap));
    push = is_in ? (commit_i && (s_ff.qn < cap)) : (host_out_i && (s_ff.armed != 2'h0));
    pop = is_in ? (host_in_i && (s_ff.qn != 2'h0)) : (skip_i && (s_ff.qn != 2'h0));
    if (push)
    begin
      nxt_s.len[s_ff.rd ^ s_ff.qn[0]] = is_in ? commit_len_i : host_len_i;
    end
    nxt_s.qn = 2'(s_ff.qn + {1'b0, push} - {1'b0, pop});
    nxt_s.rd = s_ff.rd ^ pop;
    if (!is_in)
    begin
      nxt_s.armed = 2'(s_ff.armed + {1'b0, release_buf} - {1'b0, push});
    end
    // Reconfiguring drops every buffer back to the unarmed, empty state.
    if (cfg_wr_i)
    begin
      nxt_s = '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

endmodule : ep_buffer_track
`default_nettype wire

// File: hw/bulk_in_nak_notify_and_arming.sv
// Bulk endpoint buffer control: OUT arming by skip, IN commit, IN-NAK notification.
// Assumes token strobes come from link logic on sys_clk_i and one register port.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bulk_in_nak_notify_and_arming
  import usb_ep_pkg::*;
#(
  parameter int RAM_AW = RAM_AW_DEF
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tok_in_i,
  input wire logic tok_out_i,
  input wire logic [EP_IDX_W-1:0] tok_ep_i,
  input wire logic [CNT_W-1:0] out_len_i,
  output logic hs_valid_o,
  output logic hs_nak_o,
  output logic [CNT_W-1:0] hs_len_o,
  output logic irq_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_EP-1:0][7:0] cfg;
    logic [NUM_EP-1:0][BCH_W-1:0] bc_hi;
    logic [NUM_EP-1:0] ibn_en;
    logic [NUM_EP-1:0] ibn_req;
    logic autoinc;
    logic [RAM_AW-1:0] ptr_a;
    logic [RAM_AW-1:0] ptr_b;
    logic [7:0] rdata;
    logic hs_valid;
    logic hs_nak;
    logic [CNT_W-1:0] hs_len;
    logic irq;
  } top_state_t;

  top_state_t s_ff;
  top_state_t nxt_s;
  logic [7:0] ram [2**RAM_AW];
  logic [EP_IDX_W-1:0] wr_idx;
  logic cfg_hit;
  logic bch_hit;
  logic bcl_hit;
  logic [NUM_EP-1:0] ep_ok;
  logic [NUM_EP-1:0] ep_empty;
  logic [NUM_EP-1:0] ep_full;
  logic [NUM_EP-1:0] ep_is_in;
  logic [NUM_EP-1:0] ep_act;
  logic [NUM_EP-1:0] cfg_wr;
  logic [NUM_EP-1:0] skip;
  logic [NUM_EP-1:0] commit;
  logic [NUM_EP-1:0] host_in;
  logic [NUM_EP-1:0] host_out;
  logic [NUM_EP-1:0][CNT_W-1:0] ep_head;
  logic [NUM_EP-1:0] ibn_set;
  logic [NUM_EP-1:0] ibn_clr;
  logic [CNT_W-1:0] head_sel;
  logic gl_req;
  logic gl_en;

  assign wr_idx = reg_addr_i[EP_IDX_W-1:0];
  assign cfg_hit = (reg_addr_i[7:2] == CFG_BASE[7:2]);
  assign bch_hit = (reg_addr_i[7:2] == BCH_BASE[7:2]);
  assign bcl_hit = (reg_addr_i[7:2] == BCL_BASE[7:2]);
  assign head_sel = ep_head[tok_ep_i];
  assign gl_req = |s_ff.ibn_req;
  assign gl_en = |s_ff.ibn_en;

  // ==========================================================
  // Endpoints
  for (genvar e = 0; e < NUM_EP; e++)
  begin : g_ep
    assign ep_is_in[e] = s_ff.cfg[e][CFG_DIR_BIT];
    assign ep_act[e] = s_ff.cfg[e][CFG_VALID_BIT]
                       && (s_ff.cfg[e][CFG_TYPE_MSB:CFG_TYPE_LSB] == CFG_TYPE_BULK);
    // Writes land in one cycle here, so the firmware wait is slack, not a hazard.
    assign cfg_wr[e] = reg_wr_i && cfg_hit && (wr_idx == EP_IDX_W'(e));
    assign skip[e] = reg_wr_i && bcl_hit && (wr_idx == EP_IDX_W'(e)) && !ep_is_in[e]
                     && reg_wdata_i[SKIP_BIT];
    assign commit[e] = reg_wr_i && bcl_hit && (wr_idx == EP_IDX_W'(e)) && ep_is_in[e];
    assign host_in[e] = tok_in_i && (tok_ep_i == EP_IDX_W'(e)) && ep_is_in[e] && ep_ok[e];
    assign host_out[e] = tok_out_i && (tok_ep_i == EP_IDX_W'(e)) && !ep_is_in[e] && ep_ok[e];

    ep_buffer_track u_track (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .cfg_i(s_ff.cfg[e]),
      .cfg_wr_i(cfg_wr[e]),
      .skip_i(skip[e]),
      .commit_i(commit[e]),
      .commit_len_i({s_ff.bc_hi[e], reg_wdata_i}),
      .host_out_i(host_out[e]),
      .host_len_i(out_len_i),
      .host_in_i(host_in[e]),
      .host_ok_o(ep_ok[e]),
      .empty_o(ep_empty[e]),
      .full_o(ep_full[e]),
      .head_len_o(ep_head[e])
    );
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.hs_valid = 1'b0;
    nxt_s.hs_nak = 1'b0;
    nxt_s.hs_len = '0;
    nxt_s.rdata = '0;
    ibn_set = '0;
    ibn_clr = '0;
    if (tok_in_i)
    begin
      nxt_s.hs_valid = 1'b1;
      if (ep_is_in[tok_ep_i] && ep_ok[tok_ep_i])
      begin
        nxt_s.hs_len = head_sel;
      end
      else
      begin
        nxt_s.hs_nak = 1'b1;
        ibn_set[tok_ep_i] = ep_act[tok_ep_i] && ep_is_in[tok_ep_i];
      end
    end
    else if (tok_out_i)
    begin
      nxt_s.hs_valid = 1'b1;
      nxt_s.hs_nak = !(!ep_is_in[tok_ep_i] && ep_ok[tok_ep_i]);
    end
    if (reg_wr_i)
    begin
      if (cfg_hit)
      begin
        nxt_s.cfg[wr_idx] = reg_wdata_i;
      end
      if (bch_hit)
      begin
        nxt_s.bc_hi[wr_idx] = reg_wdata_i[BCH_W-1:0];
      end
      case (reg_addr_i)
        IBN_EN_OFF: nxt_s.ibn_en = reg_wdata_i[NUM_EP-1:0];
        IBN_REQ_OFF: ibn_clr = reg_wdata_i[NUM_EP-1:0];
        APTR_SETUP_OFF: nxt_s.autoinc = reg_wdata_i[AUTOINC_BIT];
        PTR_A_OFF: nxt_s.ptr_a = reg_wdata_i[RAM_AW-1:0];
        PTR_B_OFF: nxt_s.ptr_b = reg_wdata_i[RAM_AW-1:0];
        DATA_A_OFF: nxt_s.ptr_a = s_ff.autoinc ? s_ff.ptr_a + 1'b1 : s_ff.ptr_a;
        DATA_B_OFF: nxt_s.ptr_b = s_ff.autoinc ? s_ff.ptr_b + 1'b1 : s_ff.ptr_b;
        default: ;
      endcase
    end
    if (reg_rd_i)
    begin
      if (cfg_hit)
      begin
        nxt_s.rdata = s_ff.cfg[wr_idx];
      end
      else if (bch_hit)
      begin
        nxt_s.rdata = {5'h00, ep_head[wr_idx][CNT_W-1:8]};
      end
      else if (bcl_hit)
      begin
        nxt_s.rdata = ep_head[wr_idx][7:0];
      end
      else
      begin
        case (reg_addr_i)
          EP_STAT_OFF: nxt_s.rdata = {ep_full, ep_empty};
          IBN_EN_OFF: nxt_s.rdata = {4'h0, s_ff.ibn_en};
          IBN_REQ_OFF: nxt_s.rdata = {4'h0, s_ff.ibn_req};
          GNAK_EN_OFF: nxt_s.rdata = {7'h00, gl_en};
          GNAK_REQ_OFF: nxt_s.rdata = {7'h00, gl_req};
          APTR_SETUP_OFF: nxt_s.rdata = {7'h00, s_ff.autoinc};
          PTR_A_OFF: nxt_s.rdata = 8'(s_ff.ptr_a);
          PTR_B_OFF: nxt_s.rdata = 8'(s_ff.ptr_b);
          DATA_A_OFF:
          begin
            nxt_s.rdata = ram[s_ff.ptr_a];
            nxt_s.ptr_a = s_ff.autoinc ? s_ff.ptr_a + 1'b1 : s_ff.ptr_a;
          end
          DATA_B_OFF:
          begin
            nxt_s.rdata = ram[s_ff.ptr_b];
            nxt_s.ptr_b = s_ff.autoinc ? s_ff.ptr_b + 1'b1 : s_ff.ptr_b;
          end
          default: nxt_s.rdata = 8'h00;
        endcase
      end
    end
    // A NAK in the same cycle as its clear survives; losing it would hide a waiting host.
    nxt_s.ibn_req = (s_ff.ibn_req & ~ibn_clr) | ibn_set;
    nxt_s.irq = |(nxt_s.ibn_req & nxt_s.ibn_en);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Scratch memory has no reset; its contents are undefined until written.
  always_ff @(posedge sys_clk_i)
  begin
    if (reg_wr_i && (reg_addr_i == DATA_A_OFF))
    begin
      ram[s_ff.ptr_a] <= reg_wdata_i;
    end
    else if (reg_wr_i && (reg_addr_i == DATA_B_OFF))
    begin
      ram[s_ff.ptr_b] <= reg_wdata_i;
    end
  end

  assign reg_rdata_o = s_ff.rdata;
  assign hs_valid_o = s_ff.hs_valid;
  assign hs_nak_o = s_ff.hs_nak;
  assign hs_len_o = s_ff.hs_len;
  assign irq_o = s_ff.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_skip_arm;
    reg_wr_i && bcl_hit && reg_wdata_i[SKIP_BIT] && !ep_is_in[wr_idx] && ep_act[wr_idx]
    |=> ep_ok[$past(wr_idx)];
  endproperty
  a_skip_arm: assert property (p_skip_arm) else $error("skip did not arm endpoint");

  property p_cfg_in;
    reg_wr_i && cfg_hit && (reg_wdata_i == CFG_BULK_IN_DBL)
    |=> ep_is_in[$past(wr_idx)] && ep_act[$past(wr_idx)];
  endproperty
  a_cfg_in: assert property (p_cfg_in) else $error("config value not decoded");

  property p_in_nak;
    tok_in_i && !(ep_is_in[tok_ep_i] && ep_ok[tok_ep_i]) |=> hs_valid_o && hs_nak_o;
  endproperty
  a_in_nak: assert property (p_in_nak) else $error("IN without data not NAKed");

  property p_in_data;
    tok_in_i && ep_is_in[tok_ep_i] && ep_ok[tok_ep_i]
    |=> hs_valid_o && !hs_nak_o && (hs_len_o == $past(head_sel));
  endproperty
  a_in_data: assert property (p_in_data) else $error("committed IN not answered");

  property p_nak_req;
    tok_in_i && ep_act[tok_ep_i] && ep_is_in[tok_ep_i] && !ep_ok[tok_ep_i]
    |=> s_ff.ibn_req[$past(tok_ep_i)];
  endproperty
  a_nak_req: assert property (p_nak_req) else $error("NAK did not set request");

  property p_w1c;
    reg_wr_i && (reg_addr_i == IBN_REQ_OFF) && reg_wdata_i[0] && !(tok_in_i && (tok_ep_i == 2'h0))
    |=> !s_ff.ibn_req[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("request not cleared by one");

  property p_glob;
    reg_rd_i && (reg_addr_i == GNAK_REQ_OFF) |=> reg_rdata_o[GLOBAL_IBN_BIT] == $past(gl_req);
  endproperty
  a_glob: assert property (p_glob) else $error("global request not OR of bits");

  property p_commit;
    reg_wr_i && bcl_hit && ep_is_in[wr_idx] && ep_act[wr_idx] && !ep_full[wr_idx]
    |=> ep_ok[$past(wr_idx)];
  endproperty
  a_commit: assert property (p_commit) else $error("commit not visible to host");

  property p_out_full;
    tok_out_i && !ep_ok[tok_ep_i] |=> hs_valid_o && hs_nak_o;
  endproperty
  a_out_full: assert property (p_out_full) else $error("OUT to full endpoint not NAKed");

  property p_autoinc;
    reg_rd_i && (reg_addr_i == DATA_A_OFF) && s_ff.autoinc |=> s_ff.ptr_a == $past(s_ff.ptr_a) + 1'b1;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("pointer did not advance");

  property p_irq;
    irq_o |-> gl_req && gl_en;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without global bits");

  c_skip: cover property (skip[0] ##1 host_out[0]);
  c_in_nak: cover property (tok_in_i ##1 hs_nak_o ##1 irq_o);
  c_in_data: cover property (commit[2] ##[1:20] host_in[2]);

endmodule : bulk_in_nak_notify_and_arming
`default_nettype wire

// File: tb/usb_host_model.sv
// Host side model: issues bulk IN tokens and OUT packets, returns the handshake.
// Assumes the block answers every token exactly one cycle after it is taken.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
  import usb_ep_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic hs_valid_i,
  input wire logic hs_nak_i,
  input wire logic [CNT_W-1:0] hs_len_i,
  output logic tok_in_o,
  output logic tok_out_o,
  output logic [EP_IDX_W-1:0] tok_ep_o,
  output logic [CNT_W-1:0] out_len_o
);
  // ==========================================================
  // Idle levels
  initial
  begin
    tok_in_o = 1'b0;
    tok_out_o = 1'b0;
    tok_ep_o = '0;
    out_len_o = '0;
  end

  // ==========================================================
  // One transaction
  // Qualifiers are inverted once the token is gone, so stale values never look valid.
  task automatic send(input logic is_in, input logic [EP_IDX_W-1:0] ep,
                      input logic [CNT_W-1:0] len, output logic valid,
                      output logic nak, output logic [CNT_W-1:0] got);
    @(posedge sys_clk_i);
    tok_in_o <= is_in;
    tok_out_o <= !is_in;
    tok_ep_o <= ep;
    out_len_o <= len;
    @(posedge sys_clk_i);
    tok_in_o <= 1'b0;
    tok_out_o <= 1'b0;
    tok_ep_o <= ~ep;
    out_len_o <= ~len;
    #1;
    valid = hs_valid_i;
    nak = hs_nak_i;
    got = hs_len_i;
  endtask : send
endmodule : usb_host_model
`default_nettype wire

// File: tb/bulk_in_nak_notify_and_arming_tb.sv
// Self-checking bench for the bulk endpoint buffer control block.
// Assumes the host model above and firmware-style register traffic from this bench.
`timescale 1ns/1ps
`default_nettype none
module bulk_in_nak_notify_and_arming_tb
  import usb_ep_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tok_in, tok_out, hs_valid, hs_nak, irq;
  logic [EP_IDX_W-1:0] tok_ep;
  logic [CNT_W-1:0] out_len, hs_len;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed;
  logic [CNT_W-1:0] len1, len2;
  logic [7:0] got;
  logic [7:0] dat [3];

  always #10 sys_clk = ~sys_clk;

  bulk_in_nak_notify_and_arming dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .tok_in_i(tok_in), .tok_out_i(tok_out), .tok_ep_i(tok_ep), .out_len_i(out_len),
    .hs_valid_o(hs_valid), .hs_nak_o(hs_nak), .hs_len_o(hs_len), .irq_o(irq));

  usb_host_model host (.sys_clk_i(sys_clk), .hs_valid_i(hs_valid), .hs_nak_i(hs_nak),
    .hs_len_i(hs_len), .tok_in_o(tok_in), .tok_out_o(tok_out), .tok_ep_o(tok_ep),
    .out_len_o(out_len));

  // ==========================================================
  // Expectations and compares
  function automatic logic [CNT_W-1:0] count_of(input logic [7:0] hi, input logic [7:0] lo);
    return {hi[2:0], lo};
  endfunction : count_of

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %0t register read %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk_irq(input logic e);
    @(posedge sys_clk);
    #1;
    num_checks++;
    if (irq !== e)
    begin
      failures++;
      $display("FAIL %0t interrupt %b expected %b", $time, irq, e);
    end
  endtask : chk_irq

  task automatic host_chk(input logic is_in, input logic [1:0] ep, input logic [CNT_W-1:0] len,
                          input logic e_nak, input logic [CNT_W-1:0] e_len);
    logic v;
    logic n;
    logic [CNT_W-1:0] l;
    host.send(is_in, ep, len, v, n, l);
    num_checks++;
    if (v !== 1'b1 || n !== e_nak || l !== e_len)
    begin
      failures++;
      $display("FAIL %0t handshake v%b nak%b len%h expected nak%b len%h", $time, v, n, l,
               e_nak, e_len);
    end
  endtask : host_chk

  // ==========================================================
  // Register port
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : bus_read

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus_read(a, d);
    chk8(d, e);
  endtask : rd_chk

  // Endpoint registers take effect the cycle after the write like any other; firmware still pauses two cycles after them.
  task automatic sync_wait();
    repeat (2) @(posedge sys_clk);
  endtask : sync_wait

  task automatic commit(input logic [1:0] ep, input logic [CNT_W-1:0] len);
    bus_write(BCH_BASE + 8'(ep), {5'h00, len[10:8]});
    sync_wait();
    bus_write(BCL_BASE + 8'(ep), len[7:0]);
    sync_wait();
  endtask : commit

  // ==========================================================
  // Closing report
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    seed = 57;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(IBN_EN_OFF, 8'h00);
    rd_chk(IBN_REQ_OFF, 8'h00);
    rd_chk(GNAK_REQ_OFF, 8'h00);
    rd_chk(8'h3F, 8'h00);
    rd_chk(EP_STAT_OFF, 8'h0F);
    bus_write(CFG_BASE, CFG_BULK_OUT_DBL);
    sync_wait();
    bus_write(CFG_BASE + 8'h02, CFG_BULK_IN_DBL);
    sync_wait();
    rd_chk(CFG_BASE + 8'h02, 8'hE2);
    host_chk(1'b0, 2'd0, 11'h010, 1'b1, '0);
    for (int i = 0; i < 2; i++)
    begin
      bus_write(BCL_BASE, 8'h80);
      sync_wait();
    end
    bus_read(EP_STAT_OFF, got);
    chk8(got & 8'h11, 8'h01);
    len1 = 11'($random(seed));
    len2 = 11'($random(seed));
    host_chk(1'b0, 2'd0, len1, 1'b0, '0);
    host_chk(1'b0, 2'd0, len2, 1'b0, '0);
    host_chk(1'b0, 2'd0, 11'h040, 1'b1, '0);
    bus_read(EP_STAT_OFF, got);
    chk8(got & 8'h11, 8'h10);
    rd_chk(BCH_BASE, {5'h00, len1[10:8]});
    rd_chk(BCL_BASE, len1[7:0]);
    bus_write(BCL_BASE, 8'h80);
    sync_wait();
    rd_chk(BCL_BASE, len2[7:0]);
    // A single-buffered OUT endpoint takes one skip only; the second one is ignored.
    bus_write(CFG_BASE + 8'h01, 8'hA3);
    sync_wait();
    for (int i = 0; i < 2; i++)
    begin
      bus_write(BCL_BASE + 8'h01, 8'h80);
      sync_wait();
    end
    host_chk(1'b0, 2'd1, len1, 1'b0, '0);
    host_chk(1'b0, 2'd1, len2, 1'b1, '0);
    bus_read(EP_STAT_OFF, got);
    chk8(got & 8'h22, 8'h20);
    rd_chk(BCL_BASE + 8'h01, len1[7:0]);
    host_chk(1'b0, 2'd0, len1, 1'b0, '0);
    host_chk(1'b1, 2'd2, '0, 1'b1, '0);
    rd_chk(IBN_REQ_OFF, 8'h04);
    rd_chk(GNAK_REQ_OFF, 8'h01);
    rd_chk(GNAK_EN_OFF, 8'h00);
    chk_irq(1'b0);
    bus_write(IBN_EN_OFF, 8'h04);
    rd_chk(GNAK_EN_OFF, 8'h01);
    chk_irq(1'b1);
    bus_write(IBN_REQ_OFF, 8'hFB);
    rd_chk(IBN_REQ_OFF, 8'h04);
    bus_write(IBN_EN_OFF, 8'h00);
    chk_irq(1'b0);
    bus_write(IBN_EN_OFF, 8'h04);
    chk_irq(1'b1);
    bus_write(IBN_REQ_OFF, 8'hFF);
    chk_irq(1'b0);
    rd_chk(GNAK_REQ_OFF, 8'h00);
    for (int r = 0; r < 3; r++)
    begin
      len1 = (r == 0) ? 11'h7FF : 11'($random(seed));
      len2 = 11'($random(seed));
      commit(2'd2, len1);
      commit(2'd2, len2);
      host_chk(1'b1, 2'd2, '0, 1'b0, count_of({5'h00, len1[10:8]}, len1[7:0]));
      host_chk(1'b1, 2'd2, '0, 1'b0, count_of({5'h00, len2[10:8]}, len2[7:0]));
      host_chk(1'b1, 2'd2, '0, 1'b1, '0);
    end
    bus_write(APTR_SETUP_OFF, 8'h01);
    bus_write(PTR_B_OFF, 8'h05);
    for (int i = 0; i < 3; i++)
    begin
      dat[i] = 8'($random(seed));
      bus_write(DATA_B_OFF, dat[i]);
    end
    rd_chk(PTR_B_OFF, 8'h08);
    bus_write(PTR_A_OFF, 8'h05);
    for (int i = 0; i < 3; i++)
      rd_chk(DATA_A_OFF, dat[i]);
    rd_chk(PTR_A_OFF, 8'h08);
    // With auto-increment off the pointer must hold, so the same byte comes back twice.
    bus_write(APTR_SETUP_OFF, 8'h00);
    bus_write(PTR_A_OFF, 8'h05);
    rd_chk(DATA_A_OFF, dat[0]);
    rd_chk(DATA_A_OFF, dat[0]);
    rd_chk(PTR_A_OFF, 8'h05);
    end_of_test();
  end
endmodule : bulk_in_nak_notify_and_arming_tb
`default_nettype wire
